// ===== logic/adc_ctrl_map.svh
// What this block does
// - Rising edge of selected trigger source sets the start/status flag by hardware.
// - Trigger inputs are rising-edge detected; a held high level never retriggers.
// - Trigger select bits 7-4 of control 2: 0000 none, 0001/0010 CCU 1/2, 1110/1111 reserved.
// - Codes 0011-1101 select timer overflows, timer matches, comparators, logic cells.
// - Timer 0/1 overflows used as trigger still set their own interrupt flags.
// - Channel select bits 6-2 of control 0 pick references, DACs, temperature, inputs 27-0.
// - Writing 1 to the start/status bit starts a conversion; reads 1 while busy.
// - Hardware clears the start/status flag when the conversion finishes.
// - Enable bit 0 of control 0 powers the converter; 0 disables it.
// - Justify bit 7 of control 1: 1 right, 0 left, zeroing six unused bits.
// - Clock select bits 6-4: divide 2/8/32/4/16/64 or internal RC for x11.
// - Bit 2 of control 1 selects negative reference: 0 ground, 1 pin.
// - Bits 1-0 of control 1: 00 supply, 10 pin, 11 fixed reference, 01 reserved.
// - Unimplemented bits of the control registers always read zero.
// - Left justified, the high result register holds result bits 9 to 2.
// - On completion clear start flag, pulse done flag, load both result registers.
// - A full conversion lasts eleven and a half conversion clock periods.
// - Clearing start flag mid-conversion aborts; unconverted bits copy the last bit.
// - Right justified, the low result register holds result bits 7 to 0.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define ADC_OFS_CTRL0     8'h00
`define ADC_OFS_CTRL1     8'h04
`define ADC_OFS_CTRL2     8'h08
`define ADC_OFS_RES_HIGH  8'h0c
`define ADC_OFS_RES_LOW   8'h10
`define ADC_EN_BIT        0
`define ADC_GO_BIT        1
`define ADC_CHANNEL_LSB   2
`define ADC_JUSTIFY_BIT   7
`define ADC_CLKSEL_LSB    4
`define ADC_NREF_BIT      2
`define ADC_PREF_LSB      0
`define ADC_TRIG_LSB      4
`define ADC_CTRL_RESET    8'h00
`define ADC_HALF_PERIODS  5'd23
`define ADC_FIRST_DECIDE  5'd2
`define ADC_LAST_DECIDE   5'd20
`endif

// ===== logic/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    CLK_DIV2  = 3'h0,
    CLK_DIV8  = 3'h1,
    CLK_DIV32 = 3'h2,
    CLK_RC_A  = 3'h3,
    CLK_DIV4  = 3'h4,
    CLK_DIV16 = 3'h5,
    CLK_DIV64 = 3'h6,
    CLK_RC_B  = 3'h7
  } clk_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
  typedef struct packed {
    logic       capture_compare_one;
    logic       capture_compare_two;
    logic       timer_zero_overflow;
    logic       timer_one_overflow;
    logic       timer_two_match;
    logic       comparator_one_synced;
    logic       comparator_two_synced;
    logic [3:0] logic_cell_output;
    logic       timer_four_match;
    logic       timer_six_match;
  } trig_sources_t;
  typedef struct packed {
    logic       converter_enable;
    logic [4:0] input_channel_select;
    logic       negative_ref_select;
    logic [1:0] positive_ref_select;
  } analog_cfg_t;
endpackage
`default_nettype wire

// ===== logic/adc_clock_divider.sv
`default_nettype none
module adc_clock_divider (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Control
  input  wire logic                  run,
  input  wire adc_ctrl_pkg::clk_sel_t clock_select,
  input  wire logic                  rc_edge,
  // Half conversion clock period tick
  output logic                       half_tick
);
  import adc_ctrl_pkg::*;

  logic [4:0] count_reg;
  logic [4:0] limit;

  always_comb begin
    case (clock_select)
      CLK_DIV2:  limit = 5'h00;
      CLK_DIV4:  limit = 5'h01;
      CLK_DIV8:  limit = 5'h03;
      CLK_DIV16: limit = 5'h07;
      CLK_DIV32: limit = 5'h0f;
      CLK_DIV64: limit = 5'h1f;
      default:   limit = 5'h00;
    endcase
  end

  // Internal RC selected for both x11 codes
  wire rc_mode = clock_select[1] & clock_select[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 5'h00;
    end else if (!run || count_reg == limit) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_tick <= 1'b0;
    end else begin
      half_tick <= run & (rc_mode ? rc_edge : (count_reg == limit));
    end
  end
endmodule
`default_nettype wire

// ===== logic/adc_control_and_auto_trigger.sv
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_control_and_auto_trigger (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Trigger events, internal RC clock, analog comparator code
  input  wire adc_ctrl_pkg::trig_sources_t trigger_sources,
  input  wire logic                        internal_rc_clock,
  input  wire logic [9:0]                  sampled_code,
  // Analog front end control and done event
  output adc_ctrl_pkg::analog_cfg_t        analog_config,
  output logic                             conversion_done_pulse
);
  import adc_ctrl_pkg::*;

  function automatic logic [9:0] fill_partial(input logic [9:0] sar,
                                              input logic [3:0] pos,
                                              input logic       last,
                                              input logic       any);
    logic [9:0] r;
    r = sar;
    for (int i = 0; i < 10; i++) begin
      // Once bit 0 is decided the position wraps past 9 and nothing is left to fill
      if (any && pos <= 4'h9 && i <= int'(pos)) begin
        r[i] = last;
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] justify(input logic [9:0] res, input logic right);
    return right ? {6'h00, res[9:8], res[7:0]} : {res[9:2], res[1:0], 6'h00};
  endfunction

  // Control registers
  logic        enable_reg;
  logic [4:0]  channel_reg;
  logic        justify_reg;
  clk_sel_t    clksel_reg;
  logic        nref_reg;
  logic [1:0]  pref_reg;
  logic [3:0]  trig_select_reg;
  logic [7:0]  result_high_reg;
  logic [7:0]  result_low_reg;
  // Conversion engine
  conv_state_t state_reg;
  logic [4:0]  hcnt_reg;
  logic [3:0]  bitpos_reg;
  logic [9:0]  sar_reg;
  logic [9:0]  sample_reg;
  logic        last_bit_reg;
  logic        any_bit_reg;
  // Synchronisers
  logic [12:0] trig_meta_reg;
  logic [12:0] trig_sync_reg;
  logic [12:0] trig_prev_reg;
  logic [2:0]  rc_sync_reg;
  logic [9:0]  code_meta_reg;
  logic [9:0]  code_sync_reg;
  logic        half_tick;

  // Bus decode: one wait state; writes take effect when pready is high, read data is captured in the cycle before
  wire access    = psel & penable;
  wire bus_wr    = access & pready & pwrite;
  wire wr_ctrl0  = bus_wr && paddr == `ADC_OFS_CTRL0;
  wire wr_ctrl1  = bus_wr && paddr == `ADC_OFS_CTRL1;
  wire wr_ctrl2  = bus_wr && paddr == `ADC_OFS_CTRL2;
  wire wr_rhigh  = bus_wr && paddr == `ADC_OFS_RES_HIGH;
  wire wr_rlow   = bus_wr && paddr == `ADC_OFS_RES_LOW;
  wire go_wdata  = pwdata[`ADC_GO_BIT];
  wire en_wdata  = pwdata[`ADC_EN_BIT];
  wire busy      = state_reg == ST_CONV;
  wire mapped    = paddr == `ADC_OFS_CTRL0 || paddr == `ADC_OFS_CTRL1 ||
                   paddr == `ADC_OFS_CTRL2 || paddr == `ADC_OFS_RES_HIGH ||
                   paddr == `ADC_OFS_RES_LOW;

  // Trigger edge detection per source, then selection
  wire [12:0] trig_rise = trig_sync_reg & ~trig_prev_reg;
  logic       trig_sel_rise;

  always_comb begin
    case (trig_select_reg)
      4'h1:    trig_sel_rise = trig_rise[12];
      4'h2:    trig_sel_rise = trig_rise[11];
      4'h3:    trig_sel_rise = trig_rise[10];
      4'h4:    trig_sel_rise = trig_rise[9];
      4'h5:    trig_sel_rise = trig_rise[8];
      4'h6:    trig_sel_rise = trig_rise[7];
      4'h7:    trig_sel_rise = trig_rise[6];
      4'h8:    trig_sel_rise = trig_rise[2];
      4'h9:    trig_sel_rise = trig_rise[3];
      4'ha:    trig_sel_rise = trig_rise[4];
      4'hb:    trig_sel_rise = trig_rise[5];
      4'hc:    trig_sel_rise = trig_rise[1];
      4'hd:    trig_sel_rise = trig_rise[0];
      default: trig_sel_rise = 1'b0;
    endcase
  end

  wire finish    = busy && half_tick && hcnt_reg == `ADC_HALF_PERIODS - 5'd1;
  wire sw_start  = wr_ctrl0 && go_wdata && enable_reg && en_wdata;
  wire trig_fire = trig_sel_rise && enable_reg && !busy;
  wire sw_abort  = busy && wr_ctrl0 && !go_wdata;
  wire kill      = busy && wr_ctrl0 && !en_wdata;
  // A software start in the finishing cycle wins over the hardware clear
  wire start     = (sw_start && (!busy || finish)) || trig_fire;
  wire decide    = busy && half_tick && !hcnt_reg[0] &&
                   hcnt_reg >= `ADC_FIRST_DECIDE && hcnt_reg <= `ADC_LAST_DECIDE;
  wire [9:0] cand = sar_reg | (10'h001 << bitpos_reg);

  // Input synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta_reg <= 13'h0000;
      trig_sync_reg <= 13'h0000;
      trig_prev_reg <= 13'h0000;
      rc_sync_reg   <= 3'h0;
      code_meta_reg <= 10'h000;
      code_sync_reg <= 10'h000;
    end else begin
      trig_meta_reg <= trigger_sources;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
      rc_sync_reg   <= {rc_sync_reg[1:0], internal_rc_clock};
      code_meta_reg <= sampled_code;
      code_sync_reg <= code_meta_reg;
    end
  end

  adc_clock_divider u_divider (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (busy),
    .clock_select (clksel_reg),
    .rc_edge      (rc_sync_reg[2] ^ rc_sync_reg[1]),
    .half_tick    (half_tick)
  );

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg  <= 1'b0;
      channel_reg <= 5'h00;
    end else if (wr_ctrl0) begin
      enable_reg  <= en_wdata;
      channel_reg <= pwdata[`ADC_CHANNEL_LSB +: 5];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      justify_reg <= 1'b0;
      clksel_reg  <= CLK_DIV2;
      nref_reg    <= 1'b0;
      pref_reg    <= 2'h0;
    end else if (wr_ctrl1) begin
      justify_reg <= pwdata[`ADC_JUSTIFY_BIT];
      clksel_reg  <= clk_sel_t'(pwdata[`ADC_CLKSEL_LSB +: 3]);
      nref_reg    <= pwdata[`ADC_NREF_BIT];
      pref_reg    <= pwdata[`ADC_PREF_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_select_reg <= 4'h0;
    end else if (wr_ctrl2) begin
      trig_select_reg <= pwdata[`ADC_TRIG_LSB +: 4];
    end
  end

  // Conversion sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (kill || sw_abort || (finish && !start)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Successive approximation, one decision per conversion clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_reg     <= 5'h00;
      bitpos_reg   <= 4'h9;
      sar_reg      <= 10'h000;
      sample_reg   <= 10'h000;
      last_bit_reg <= 1'b0;
      any_bit_reg  <= 1'b0;
    end else if (start) begin
      hcnt_reg     <= 5'h00;
      bitpos_reg   <= 4'h9;
      sar_reg      <= 10'h000;
      sample_reg   <= code_sync_reg;
      last_bit_reg <= 1'b0;
      any_bit_reg  <= 1'b0;
    end else if (busy && half_tick) begin
      hcnt_reg <= hcnt_reg + 5'h01;
      if (decide) begin
        bitpos_reg   <= bitpos_reg - 4'h1;
        last_bit_reg <= cand <= sample_reg;
        any_bit_reg  <= 1'b1;
        if (cand <= sample_reg) begin
          sar_reg <= cand;
        end
      end
    end
  end

  // Result registers: a hardware load beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_reg <= 8'h00;
      result_low_reg  <= 8'h00;
    end else if (finish) begin
      {result_high_reg, result_low_reg} <= justify(sar_reg, justify_reg);
    end else if (sw_abort) begin
      {result_high_reg, result_low_reg} <=
        justify(fill_partial(sar_reg, bitpos_reg, last_bit_reg, any_bit_reg),
                justify_reg);
    end else begin
      if (wr_rhigh) begin
        result_high_reg <= pwdata[7:0];
      end
      if (wr_rlow) begin
        result_low_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_pulse <= 1'b0;
    end else begin
      conversion_done_pulse <= finish;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_config <= '0;
    end else begin
      analog_config <= {enable_reg, channel_reg, nref_reg, pref_reg};
    end
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready && !pwrite) begin
        case (paddr)
          `ADC_OFS_CTRL0:    prdata <= {24'h0, 1'b0, channel_reg, busy, enable_reg};
          `ADC_OFS_CTRL1:    prdata <= {24'h0, justify_reg, clksel_reg, 1'b0,
                                        nref_reg, pref_reg};
          `ADC_OFS_CTRL2:    prdata <= {24'h0, trig_select_reg, 4'h0};
          `ADC_OFS_RES_HIGH: prdata <= {24'h0, result_high_reg};
          `ADC_OFS_RES_LOW:  prdata <= {24'h0, result_low_reg};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_trig_starts: assert property (trig_fire |=> busy && hcnt_reg == 5'h00)
    else $error("trigger edge did not start conversion");
  // A level that has not moved since the last sample must never look like an edge
  a_level_once: assert property ($past(trig_sync_reg) == trig_sync_reg
                                 |-> trig_rise == 13'h0)
    else $error("held trigger level retriggered");
  a_no_trig_sel: assert property (trig_select_reg == 4'h0 || trig_select_reg >= 4'he
                                  |-> !trig_sel_rise)
    else $error("edge seen with no or reserved trigger");
  a_busy_enabled: assert property (busy |-> enable_reg)
    else $error("conversion running while disabled");
  a_ignore_busy: assert property (busy && !start && trig_sel_rise |=> $stable(sample_reg))
    else $error("trigger restarted busy conversion");
  a_done_clears: assert property (finish && !start |=> !busy ##0 conversion_done_pulse)
    else $error("completion did not clear flag and pulse done");
  a_right_zero: assert property (finish && justify_reg |=> result_high_reg[7:2] == 6'h00
                                 && result_low_reg == $past(sar_reg[7:0]))
    else $error("right justified result wrong");
  a_left_high: assert property (finish && !justify_reg
                                |=> result_high_reg == $past(sar_reg[9:2])
                                && result_low_reg[5:0] == 6'h00)
    else $error("left justified result wrong");
  a_ctrl_zero: assert property (pready && paddr == `ADC_OFS_CTRL1 && !pwrite
                                |-> prdata[3] == 1'b0)
    else $error("unimplemented bit read as one");
  a_ctrl0_zero: assert property (pready && paddr == `ADC_OFS_CTRL0 && !pwrite
                                 |-> prdata[7] == 1'b0)
    else $error("control 0 unimplemented bit read as one");
  a_ctrl2_zero: assert property (pready && paddr == `ADC_OFS_CTRL2 && !pwrite
                                 |-> prdata[3:0] == 4'h0)
    else $error("control 2 unimplemented bits read as one");
  a_busy_reads: assert property (pready && paddr == `ADC_OFS_CTRL0 && !pwrite
                                 |-> prdata[1] == $past(busy))
    else $error("start flag read does not show busy");
  a_sw_start: assert property (sw_start && !busy |=> busy ##1 busy)
    else $error("software start lost");
  a_abort_idle: assert property (sw_abort && !finish |=> !busy && !conversion_done_pulse)
    else $error("abort left conversion running or pulsed done");
  a_disable_stops: assert property (kill |=> !busy && !enable_reg)
    else $error("disable did not stop conversion");
  a_off_no_start: assert property (!enable_reg && !busy |=> !busy)
    else $error("disabled converter started");
  a_cfg_follows: assert property (analog_config.converter_enable == $past(enable_reg))
    else $error("power control does not follow enable bit");

  // Scenarios reached
  c_trig_conv: cover property (trig_fire ##[1:1000] finish);
  c_abort: cover property (sw_abort && any_bit_reg);
  c_restart: cover property (finish && start);
  c_rc_conv: cover property (finish && clksel_reg[1:0] == 2'b11);
  c_disable: cover property (kill);
endmodule
`default_nettype wire

// ===== dv/trig_source_model.sv
`default_nettype none
module trig_source_model (
  // Clock
  input  wire logic                   pclk,
  // Event sources and analog side
  output adc_ctrl_pkg::trig_sources_t trigger_sources,
  output logic                        internal_rc_clock,
  output logic [9:0]                  sampled_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;

  logic [12:0] level;

  assign trigger_sources = trig_sources_t'(level);

  // Free running RC oscillator, unrelated in phase to pclk
  initial internal_rc_clock = 1'b0;
  always #23.7 internal_rc_clock = ~internal_rc_clock;

  initial begin
    level = 13'h0000;
    sampled_code = 10'h000;
  end

  // Sources are plain levels; nothing here spaces conversions apart
  task automatic raise(input int idx);
    @(posedge pclk);
    level[idx] <= 1'b1;
  endtask

  task automatic raise_all();
    @(posedge pclk);
    level <= 13'h1fff;
  endtask

  task automatic clear_all();
    @(posedge pclk);
    level <= 13'h0000;
  endtask

  task automatic set_code(input logic [9:0] c);
    @(posedge pclk);
    sampled_code <= c;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
`include "adc_ctrl_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;

  logic          pclk = 1'b0;
  logic          presetn;
  logic [7:0]    paddr;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  trig_sources_t trigger_sources;
  logic          internal_rc_clock;
  logic [9:0]    sampled_code;
  analog_cfg_t   analog_config;
  logic          conversion_done_pulse;
  int            fail_count = 0;
  int            num_checks = 0;
  int            done_count = 0;
  int            cyc = 0;
  int            t_done = 0;
  logic [31:0]   rng = 32'd28532;

  always #5 pclk = ~pclk;

  adc_control_and_auto_trigger DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_sources(trigger_sources), .internal_rc_clock(internal_rc_clock),
    .sampled_code(sampled_code), .analog_config(analog_config),
    .conversion_done_pulse(conversion_done_pulse));

  trig_source_model partner (
    .pclk(pclk), .trigger_sources(trigger_sources),
    .internal_rc_clock(internal_rc_clock), .sampled_code(sampled_code));

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conversion_done_pulse === 1'b1) begin
      done_count <= done_count + 1;
      t_done <= cyc;
    end
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic int src_bit(input int c);
    return (c >= 8 && c <= 11) ? c - 6 : 13 - c;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    chk("pready seen", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(what, {24'h000000, exp}, r);
  endtask

  task automatic wait_done(input int d0);
    int n;
    n = 0;
    while (done_count == d0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("done pulse arrived", 32'h1, {31'h0, done_count != d0});
  endtask

  task automatic res_chk(input logic [9:0] c, input logic right);
    rdc("result_high", `ADC_OFS_RES_HIGH, right ? {6'h00, c[9:8]} : c[9:2]);
    rdc("result_low", `ADC_OFS_RES_LOW, right ? c[7:0] : {c[1:0], 6'h00});
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    #200_000;
    fail_count++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin : main
    logic [31:0] r;
    logic        e;
    logic [7:0]  v0;
    logic [7:0]  v1;
    logic [9:0]  code;
    logic        right;
    int          d0;
    int          t0;
    int          lo;
    int          half [8];
    logic [2:0]  sel [8];
    half = '{2, 4, 8, 16, 32, 64, 0, 0};
    sel = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl0 reset", `ADC_OFS_CTRL0, 8'h00);
    rdc("ctrl1 reset", `ADC_OFS_CTRL1, 8'h00);
    rdc("ctrl2 reset", `ADC_OFS_CTRL2, 8'h00);
    apb(1'b0, 8'h14, 8'h00, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    end_test("reset");

    for (int i = 0; i < 8; i++) begin
      v0 = 8'(xs()) & 8'h7d;
      v1 = 8'(xs());
      wr(`ADC_OFS_CTRL0, v0);
      wr(`ADC_OFS_CTRL1, v1);
      wr(`ADC_OFS_CTRL2, v1);
      rdc("ctrl0 back", `ADC_OFS_CTRL0, v0);
      rdc("ctrl1 back", `ADC_OFS_CTRL1, v1 & 8'hf7);
      rdc("ctrl2 back", `ADC_OFS_CTRL2, v1 & 8'hf0);
      chk("analog_config", {23'h0, v0[0], v0[6:2], v1[2], v1[1:0]}, 32'(analog_config));
    end
    wr(`ADC_OFS_CTRL2, 8'h00);
    end_test("fields");

    for (int i = 0; i < 8; i++) begin
      code = 10'(xs());
      right = code[0];
      partner.set_code(code);
      wr(`ADC_OFS_CTRL1, {right, sel[i], 4'h0});
      wr(`ADC_OFS_CTRL0, 8'h01);
      d0 = done_count;
      wr(`ADC_OFS_CTRL0, 8'h03);
      t0 = cyc;
      rdc("busy", `ADC_OFS_CTRL0, 8'h03);
      wait_done(d0);
      lo = 23 * half[i] / 2;
      if (half[i] != 0) begin
        chk("conversion time", 32'h1,
            {31'h0, (t_done - t0 >= lo - 1) && (t_done - t0 <= lo + half[i] + 4)});
      end
      rdc("busy cleared", `ADC_OFS_CTRL0, 8'h01);
      res_chk(code, right);
    end
    end_test("software start");

    wr(`ADC_OFS_CTRL1, 8'h80);
    for (int c = 1; c < 14; c++) begin
      wr(`ADC_OFS_CTRL2, {c[3:0], 4'h0});
      code = 10'(xs());
      partner.set_code(code);
      repeat (3) @(posedge pclk);
      d0 = done_count;
      partner.raise(src_bit(c));
      repeat (6) @(posedge pclk);
      rdc("trigger start", `ADC_OFS_CTRL0, 8'h03);
      wait_done(d0);
      res_chk(code, 1'b1);
      repeat (40) @(posedge pclk);
      chk("held level", d0 + 1, done_count);
      partner.clear_all();
    end
    for (int c = 0; c < 3; c++) begin
      wr(`ADC_OFS_CTRL2, c == 0 ? 8'h00 : {2'b11, c[1:0] + 2'd1, 4'h0});
      d0 = done_count;
      partner.raise_all();
      repeat (30) @(posedge pclk);
      chk("no trigger", d0, done_count);
      partner.clear_all();
    end
    wr(`ADC_OFS_CTRL2, 8'h30);
    wr(`ADC_OFS_CTRL0, 8'h00);
    d0 = done_count;
    partner.raise(10);
    repeat (40) @(posedge pclk);
    chk("disabled trigger", d0, done_count);
    partner.clear_all();
    wr(`ADC_OFS_CTRL0, 8'h01);
    wr(`ADC_OFS_CTRL1, 8'ha0);
    d0 = done_count;
    wr(`ADC_OFS_CTRL0, 8'h03);
    partner.raise(10);
    wait_done(d0);
    repeat (400) @(posedge pclk);
    chk("busy trigger", d0 + 1, done_count);
    partner.clear_all();
    end_test("auto trigger");

    wr(`ADC_OFS_CTRL2, 8'h00);
    wr(`ADC_OFS_CTRL1, 8'he0);
    partner.set_code(10'h3ff);
    d0 = done_count;
    wr(`ADC_OFS_CTRL0, 8'h03);
    wr(`ADC_OFS_CTRL0, 8'h01);
    rdc("abort busy", `ADC_OFS_CTRL0, 8'h01);
    res_chk(10'h000, 1'b1);
    repeat (800) @(posedge pclk);
    chk("abort no done", d0, done_count);
    // Divide by 2: bits 9 to 6 are decided when the abort write lands
    partner.set_code(10'h155);
    wr(`ADC_OFS_CTRL1, 8'h80);
    wr(`ADC_OFS_CTRL0, 8'h03);
    repeat (8) @(posedge pclk);
    wr(`ADC_OFS_CTRL0, 8'h01);
    res_chk(10'h17f, 1'b1);
    wr(`ADC_OFS_CTRL0, 8'h03);
    wr(`ADC_OFS_CTRL0, 8'h00);
    rdc("disable stop", `ADC_OFS_CTRL0, 8'h00);
    chk("enable off", 32'h0, {31'h0, analog_config.converter_enable});
    end_test("abort");

    wr(`ADC_OFS_CTRL1, 8'h95);
    wr(`ADC_OFS_CTRL0, 8'h01);
    wr(`ADC_OFS_CTRL0, 8'h03);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl0 rereset", `ADC_OFS_CTRL0, 8'h00);
    rdc("ctrl1 rereset", `ADC_OFS_CTRL1, 8'h00);
    chk("config rereset", 32'h0, 32'(analog_config));
    end_test("second reset");
    print_verdict();
  end
endmodule
`default_nettype wire
